// file: logic/qusfs_defs.vh
// Constants for the quad UART serial pin and FIFO status block
`ifndef QUSFS_DEFS_VH
`define QUSFS_DEFS_VH

// Channel count and status summary layout
`define QUSFS_CHANNELS 4
`define QUSFS_SUMMARY_W 8
`define QUSFS_SUM_TX_LSB 0
`define QUSFS_SUM_RX_LSB 4

// Sixteen ticks of the 16x baud clock make one bit
`define QUSFS_BIT_TICKS 5'h10
// Infrared pulse is three sixteenths of a bit
`define QUSFS_IR_PULSE_TICKS 4'h3

// Pin levels after reset and at rest
`define QUSFS_TX_IDLE_STD 1'b1
`define QUSFS_TX_IDLE_IR 1'b0
`define QUSFS_RX_IDLE_STD 1'b1
`define QUSFS_MODEM_OUT_RESET 1'b1
`define QUSFS_READY_N_RESET 1'b1
`define QUSFS_PIN_IN_RESET 1'b1

`endif

// file: logic/qusfs_ir_codec.v
// One channel's transmit pin selection and infrared encoder/decoder
`timescale 1ns/1ns
`include "qusfs_defs.vh"

module qusfs_ir_codec (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Transmitter and receiver side
	input wire baud16_tick,
	input wire bit_start,
	input wire tx_bit,
	input wire ir_mode,
	output reg rx_bit_reg,
	// Synchronised receive pin
	input wire rx_pin,
	// Transmit pins
	output reg ser_tx_reg,
	output reg ir_tx_reg
);

reg pulse_on_reg;
reg [3:0] pulse_cnt_reg;
reg rx_prev_reg;
reg [4:0] low_cnt_reg;
wire rx_rise;

assign rx_rise = rx_pin & ~rx_prev_reg;

// Encoder: a zero bit becomes a short high pulse, a one bit stays low
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		pulse_on_reg <= 1'b0;
		pulse_cnt_reg <= 4'h0;
	end else if (bit_start) begin
		pulse_on_reg <= ~tx_bit;
		pulse_cnt_reg <= 4'h0;
	end else if (baud16_tick && pulse_on_reg) begin
		pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
		if (pulse_cnt_reg == `QUSFS_IR_PULSE_TICKS - 4'h1) begin
			pulse_on_reg <= 1'b0;
		end
	end
end

// Pin drivers
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		ser_tx_reg <= `QUSFS_TX_IDLE_STD;
		ir_tx_reg <= `QUSFS_TX_IDLE_IR;
	end else begin
		ser_tx_reg <= ir_mode ? pulse_on_reg : tx_bit;
		ir_tx_reg <= pulse_on_reg;
	end
end

// Decoder: each pulse marks a zero bit held for one bit time
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		// Matches the synchroniser's reset level: no false edge
		rx_prev_reg <= `QUSFS_RX_IDLE_STD;
		low_cnt_reg <= 5'h00;
		rx_bit_reg <= `QUSFS_RX_IDLE_STD;
	end else begin
		rx_prev_reg <= rx_pin;
		if (ir_mode && rx_rise) begin
			low_cnt_reg <= `QUSFS_BIT_TICKS;
		end else if (baud16_tick && low_cnt_reg != 5'h00) begin
			low_cnt_reg <= low_cnt_reg - 5'h01;
		end
		// Standard mode passes the line, which idles high
		rx_bit_reg <= ir_mode ? (low_cnt_reg == 5'h00 && !rx_rise) : rx_pin;
	end
end

endmodule

// file: logic/qusfs_top.v
// Quad UART serial, modem pin and FIFO status read port logic
// Notes on behaviour
// - Select low drives status summary onto bus
// - Low bits are inverted transmit-ready levels
// - High bits are raw receive-ready levels
// - Status read ignores host address entirely
// - Standard mode transmit idles high, also reset
// - Infrared mode uses codec, transmit idles low
// - Infrared output always encoded, idles low
// - Request-to-send software output, auto flow gated
// - Clear-to-send readable, gates transmit in auto
// - Terminal-ready is plain software output
// - Set-ready readable only, no effect
// - Carrier-detect readable only, no effect
// - Ready outputs follow FIFO status per channel
`timescale 1ns/1ns
`include "qusfs_defs.vh"

module qusfs_top #(
	parameter CHANNELS = `QUSFS_CHANNELS
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// Host status read port
	input wire fifo_status_select_n,
	output reg [`QUSFS_SUMMARY_W-1:0] host_data_out_reg,
	output reg host_data_oe_reg,
	// Per-channel control bits from software
	input wire [CHANNELS-1:0] infrared_enable,
	input wire [CHANNELS-1:0] rts_request,
	input wire [CHANNELS-1:0] dtr_request,
	input wire [CHANNELS-1:0] auto_rts_enable,
	input wire [CHANNELS-1:0] auto_rts_int_enable,
	input wire [CHANNELS-1:0] auto_cts_enable,
	input wire [CHANNELS-1:0] auto_cts_int_enable,
	// Per-channel transmitter and receiver core signals
	input wire [CHANNELS-1:0] baud16_tick,
	input wire [CHANNELS-1:0] tx_bit_start,
	input wire [CHANNELS-1:0] tx_serial_bit,
	input wire [CHANNELS-1:0] tx_fifo_ready,
	input wire [CHANNELS-1:0] rx_fifo_ready,
	input wire [CHANNELS-1:0] rx_fifo_above_trigger,
	output wire [CHANNELS-1:0] rx_serial_bit,
	output reg [CHANNELS-1:0] tx_hold_reg,
	// Per-channel readable modem input states, high when asserted
	output reg [CHANNELS-1:0] cts_state_reg,
	output reg [CHANNELS-1:0] dsr_state_reg,
	output reg [CHANNELS-1:0] cd_state_reg,
	// Serial pins
	output wire [CHANNELS-1:0] serial_transmit_out,
	output wire [CHANNELS-1:0] infrared_transmit_out,
	input wire [CHANNELS-1:0] serial_receive_in,
	// Modem pins
	output reg [CHANNELS-1:0] request_to_send_n,
	input wire [CHANNELS-1:0] clear_to_send_n,
	output reg [CHANNELS-1:0] terminal_ready_n,
	input wire [CHANNELS-1:0] set_ready_n,
	input wire [CHANNELS-1:0] carrier_detect_n,
	// FIFO status pins
	output reg [CHANNELS-1:0] transmit_ready_n,
	output reg [CHANNELS-1:0] receive_ready_n
);

// Reset release: asserts at once, leaves on the clock
reg rst_meta_reg;
reg rst_n;

always @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		rst_meta_reg <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta_reg <= 1'b1;
		rst_n <= rst_meta_reg;
	end
end

// Pin input synchronisers; first stage feeds only the second
reg sel_meta_reg;
reg sel_sync_reg;
reg [CHANNELS-1:0] rx_meta_reg;
reg [CHANNELS-1:0] rx_sync_reg;
reg [CHANNELS-1:0] cts_meta_reg;
reg [CHANNELS-1:0] cts_sync_reg;
reg [CHANNELS-1:0] dsr_meta_reg;
reg [CHANNELS-1:0] dsr_sync_reg;
reg [CHANNELS-1:0] cd_meta_reg;
reg [CHANNELS-1:0] cd_sync_reg;

// Select pin; the board pull-up keeps it idle when open
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		sel_meta_reg <= `QUSFS_PIN_IN_RESET;
		sel_sync_reg <= `QUSFS_PIN_IN_RESET;
	end else begin
		sel_meta_reg <= fifo_status_select_n;
		sel_sync_reg <= sel_meta_reg;
	end
end

// Serial and modem pins of every channel
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		rx_meta_reg <= {CHANNELS{`QUSFS_RX_IDLE_STD}};
		rx_sync_reg <= {CHANNELS{`QUSFS_RX_IDLE_STD}};
		cts_meta_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
		cts_sync_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
		dsr_meta_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
		dsr_sync_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
		cd_meta_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
		cd_sync_reg <= {CHANNELS{`QUSFS_PIN_IN_RESET}};
	end else begin
		rx_meta_reg <= serial_receive_in;
		rx_sync_reg <= rx_meta_reg;
		cts_meta_reg <= clear_to_send_n;
		cts_sync_reg <= cts_meta_reg;
		dsr_meta_reg <= set_ready_n;
		dsr_sync_reg <= dsr_meta_reg;
		cd_meta_reg <= carrier_detect_n;
		cd_sync_reg <= cd_meta_reg;
	end
end

// Per-channel pin logic
genvar ch;
generate
	for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
		wire auto_rts_on;
		wire auto_cts_on;
		wire rts_next;
		wire tx_hold_next;

		// Auto modes need both the feature bit and its enable bit
		assign auto_rts_on = auto_rts_enable[ch] & auto_rts_int_enable[ch];
		assign auto_cts_on = auto_cts_enable[ch] & auto_cts_int_enable[ch];
		// Software must set the request bit first; auto mode
		// only withdraws it while the receiver is too full
		assign rts_next = rts_request[ch] &
			~(auto_rts_on & rx_fifo_above_trigger[ch]);
		// Deasserted clear-to-send stalls the transmitter
		assign tx_hold_next = auto_cts_on & cts_sync_reg[ch];

		qusfs_ir_codec qusfs_ir_codec_i (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.baud16_tick(baud16_tick[ch]),
			.bit_start(tx_bit_start[ch]),
			.tx_bit(tx_serial_bit[ch]),
			.ir_mode(infrared_enable[ch]),
			.rx_bit_reg(rx_serial_bit[ch]),
			.rx_pin(rx_sync_reg[ch]),
			.ser_tx_reg(serial_transmit_out[ch]),
			.ir_tx_reg(infrared_transmit_out[ch])
		);

		// Modem control outputs under software control
		always @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				request_to_send_n[ch] <= `QUSFS_MODEM_OUT_RESET;
				terminal_ready_n[ch] <= `QUSFS_MODEM_OUT_RESET;
			end else begin
				request_to_send_n[ch] <= ~rts_next;
				terminal_ready_n[ch] <= ~dtr_request[ch];
			end
		end

		// Flow-control hold and readable modem input states
		always @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				tx_hold_reg[ch] <= 1'b0;
				cts_state_reg[ch] <= 1'b0;
				dsr_state_reg[ch] <= 1'b0;
				cd_state_reg[ch] <= 1'b0;
			end else begin
				tx_hold_reg[ch] <= tx_hold_next;
				cts_state_reg[ch] <= ~cts_sync_reg[ch];
				// Readable only; nothing else looks at these
				dsr_state_reg[ch] <= ~dsr_sync_reg[ch];
				cd_state_reg[ch] <= ~cd_sync_reg[ch];
			end
		end

		// FIFO ready pins
		always @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				transmit_ready_n[ch] <= `QUSFS_READY_N_RESET;
				receive_ready_n[ch] <= `QUSFS_READY_N_RESET;
			end else begin
				transmit_ready_n[ch] <= ~tx_fifo_ready[ch];
				receive_ready_n[ch] <= ~rx_fifo_ready[ch];
			end
		end
	end
endgenerate

// Built from the flops that drive the ready pins, so the
// bus never disagrees with them; costs one cycle of lag
wire [`QUSFS_SUMMARY_W-1:0] summary;
assign summary[`QUSFS_SUM_TX_LSB +: 4] = ~transmit_ready_n[3:0];
assign summary[`QUSFS_SUM_RX_LSB +: 4] = receive_ready_n[3:0];

// No address input exists: the select alone makes the read
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		host_data_oe_reg <= 1'b0;
	end else begin
		host_data_oe_reg <= ~sel_sync_reg;
	end
end

// Bus data parks at zero when not selected, so a stray
// enable never shows a stale summary
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		host_data_out_reg <= {`QUSFS_SUMMARY_W{1'b0}};
	end else begin
		host_data_out_reg <= sel_sync_reg ? {`QUSFS_SUMMARY_W{1'b0}} :
			summary;
	end
end

endmodule

// file: tb/qusfs_properties.sv
// Concurrent checks on the quad UART pin block ports
`timescale 1ns/1ns
module qusfs_properties #(
	parameter CHANNELS = 4
) (
	input wire logic clk_sys, rst_b, fifo_status_select_n, host_data_oe_reg,
	input wire logic [7:0] host_data_out_reg,
	input wire logic [CHANNELS-1:0] infrared_enable, rts_request, dtr_request,
	input wire logic [CHANNELS-1:0] auto_rts_enable, auto_rts_int_enable,
	input wire logic [CHANNELS-1:0] rx_fifo_above_trigger, tx_bit_start,
	input wire logic [CHANNELS-1:0] tx_serial_bit, tx_fifo_ready, rx_fifo_ready,
	input wire logic [CHANNELS-1:0] serial_transmit_out, infrared_transmit_out,
	input wire logic [CHANNELS-1:0] request_to_send_n, terminal_ready_n,
	input wire logic [CHANNELS-1:0] clear_to_send_n, cts_state_reg,
	input wire logic [CHANNELS-1:0] transmit_ready_n, receive_ready_n
);
	// Inner reset lifts two edges after the pin; wait for settling
	logic [2:0] live_cnt = 3'd0;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			live_cnt <= 3'd0;
		else if (live_cnt != 3'd4)
			live_cnt <= live_cnt + 3'd1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (live_cnt != 3'd4);
	// Select must outlast the two sync stages
	sequence s_sel_low; !fifo_status_select_n [*4]; endsequence
	sequence s_zero_bit; tx_bit_start[0] && !tx_serial_bit[0]; endsequence
	property p_sel_drive; s_sel_low |-> host_data_oe_reg; endproperty
	property p_sel_idle; fifo_status_select_n [*4] |->
		!host_data_oe_reg && host_data_out_reg == 8'h00; endproperty
	property p_summary; host_data_oe_reg |-> host_data_out_reg ==
		{$past(receive_ready_n), ~$past(transmit_ready_n)}; endproperty
	property p_std_tx; !infrared_enable[0] && tx_bit_start[0] |=>
		serial_transmit_out[0] == $past(tx_serial_bit[0]); endproperty
	property p_ir_pulse; s_zero_bit |-> ##2 infrared_transmit_out[0];
	endproperty
	property p_rts; 1'b1 |=> request_to_send_n == ~$past(rts_request &
		~(auto_rts_enable & auto_rts_int_enable & rx_fifo_above_trigger));
	endproperty
	property p_dtr; 1'b1 |=> terminal_ready_n == ~$past(dtr_request);
	endproperty
	property p_cts; $stable(clear_to_send_n) [*4] |->
		cts_state_reg == ~clear_to_send_n; endproperty
	property p_ready; 1'b1 |=> transmit_ready_n == ~$past(tx_fifo_ready) &&
		receive_ready_n == ~$past(rx_fifo_ready); endproperty
	a_sel_drive: assert property (p_sel_drive) else $error("not driven");
	a_sel_idle: assert property (p_sel_idle) else $error("bus busy");
	a_summary: assert property (p_summary) else $error("bad sum");
	a_std_tx: assert property (p_std_tx) else $error("bad tx pin");
	a_ir_pulse: assert property (p_ir_pulse) else $error("no pulse");
	a_rts: assert property (p_rts) else $error("bad rts pin");
	a_dtr: assert property (p_dtr) else $error("bad dtr pin");
	a_cts: assert property (p_cts) else $error("bad cts state");
	a_ready: assert property (p_ready) else $error("bad ready");
endmodule
bind qusfs_top qusfs_properties #(.CHANNELS(CHANNELS)) qusfs_properties_i (.*);

// file: tb/qusfs_remote.sv
// Remote terminal model facing the serial and modem pins
`timescale 1ns/1ns
module qusfs_remote (
	input wire logic clk_sys, loop_on,
	input wire logic [3:0] stall, status_n, serial_transmit_out,
	input wire logic [3:0] infrared_enable,
	output logic [3:0] serial_receive_in = 4'hf,
	output wire logic [3:0] clear_to_send_n, set_ready_n, carrier_detect_n
);
	// Echo only when asked; silent: high standard, low infrared
	always @(posedge clk_sys) begin
		serial_receive_in <= loop_on ? serial_transmit_out :
			~infrared_enable;
	end
	// Slow remote holds clear-to-send off
	assign clear_to_send_n = stall;
	assign set_ready_n = status_n;
	assign carrier_detect_n = {status_n[1:0], status_n[3:2]};
endmodule

// file: tb/qusfs_top_tb_top.sv
// Self-checking bench for the quad UART pin and status block
`timescale 1ns/1ns
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
	failures++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module qusfs_top_tb_top;
	logic clk_sys = 0, rst_b = 0, fifo_status_select_n = 1, loop_on = 0;
	logic [3:0] infrared_enable = 0, rts_request = 0, dtr_request = 0;
	logic [3:0] auto_rts_enable = 0, auto_cts_enable = 0, stall = 0;
	logic [3:0] tx_bit_start = 0, tx_serial_bit = 4'hf, status_n = 4'hf;
	logic [3:0] tx_fifo_ready = 0, rx_fifo_ready = 0, rx_fifo_above_trigger = 0;
	wire [3:0] baud16_tick = 4'hf;
	wire [3:0] auto_rts_int_enable = auto_rts_enable;
	wire [3:0] auto_cts_int_enable = auto_cts_enable;
	wire [7:0] host_data_out_reg;
	wire host_data_oe_reg;
	wire [3:0] rx_serial_bit, tx_hold_reg, cts_state_reg, dsr_state_reg;
	wire [3:0] cd_state_reg, serial_transmit_out, infrared_transmit_out;
	wire [3:0] serial_receive_in, request_to_send_n, clear_to_send_n;
	wire [3:0] terminal_ready_n, set_ready_n, carrier_detect_n;
	wire [3:0] transmit_ready_n, receive_ready_n;
	int failures = 0, compares = 0, cycles = 0;
	qusfs_top qusfs_top_i (.*);
	qusfs_remote qusfs_remote_i (.*);
	initial forever #2 clk_sys = ~clk_sys;
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Run has under 200 cycles of work
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			close_out;
		end
	end
	task t_status;
		for (int i = 0; i < 2; i++) begin
			tx_fifo_ready <= i ? 4'h5 : 4'hc;
			rx_fifo_ready <= i ? 4'h9 : 4'h6;
			fifo_status_select_n <= 0;
			cyc(5);
			`CHK("oe", 1'b1, host_data_oe_reg)
			`CHK("sum lo", tx_fifo_ready, host_data_out_reg[3:0])
			`CHK("sum hi", ~rx_fifo_ready, host_data_out_reg[7:4])
			fifo_status_select_n <= 1;
			cyc(5);
			`CHK("oe off", 1'b0, host_data_oe_reg)
		end
		$display("status read done");
	endtask
	task t_modem;
		rts_request <= 4'ha;
		dtr_request <= 4'h6;
		stall <= 4'h3;
		status_n <= 4'h9;
		auto_cts_enable <= 4'h1;
		cyc(6);
		`CHK("rts", 4'h5, request_to_send_n)
		`CHK("dtr", 4'h9, terminal_ready_n)
		`CHK("cts", 4'hc, cts_state_reg)
		`CHK("hold", 4'h1, tx_hold_reg)
		`CHK("dsr", 4'h6, dsr_state_reg)
		`CHK("cd", 4'h9, cd_state_reg)
		auto_rts_enable <= 4'h2;
		rx_fifo_above_trigger <= 4'h3;
		cyc(3);
		`CHK("auto rts", 4'h7, request_to_send_n)
		stall <= 0;
		$display("modem pins done");
	endtask
	task t_tx(input logic echo);
		loop_on <= echo;
		infrared_enable <= 4'h2;
		cyc(2);
		tx_bit_start <= 4'h3;
		tx_serial_bit <= 4'hc;
		cyc(1);
		tx_bit_start <= 0;
		cyc(echo ? 9 : 3);
		if (echo)
			`CHK("rx", 4'hc, rx_serial_bit)
		else begin
			`CHK("ir", 4'h3, infrared_transmit_out)
			`CHK("tx", 4'he, serial_transmit_out)
		end
		tx_bit_start <= 4'h3;
		tx_serial_bit <= 4'hf;
		cyc(1);
		tx_bit_start <= 0;
		loop_on <= 0;
		cyc(24);
		`CHK("tx idle", 4'hd, serial_transmit_out)
		`CHK("ir idle", 4'h0, infrared_transmit_out)
		`CHK("rx idle", 4'hf, rx_serial_bit)
		$display("serial pass done");
	endtask
	initial begin
		cyc(3);
		rst_b <= 1;
		cyc(4);
		t_status;
		t_modem;
		t_tx(0);
		t_tx(1);
		close_out;
	end
endmodule
